/* File: dv/can_bus_node.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// far side: bit timing and outcome of each started frame
module can_bus_node (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // from the block (tx_start) and the testbench (outcome)
   input  wire logic       tx_start,
   input  wire logic [1:0] outcome,
   // to the block
   output logic            bit_tick,
   output logic            arb_lost,
   output logic            tx_fail,
   output logic            tx_ok
);
   logic [1:0] tick_cnt;
   logic [2:0] wait_cnt;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tick_cnt <= 2'h0;
         wait_cnt <= 3'h0;
         {bit_tick, arb_lost, tx_fail, tx_ok} <= 4'h0;
      end else begin
         tick_cnt <= tick_cnt + 2'h1;
         bit_tick <= (tick_cnt == 2'h3);
         // outcome 0 ok, 1 failed after winning, 2 lost arbitration
         wait_cnt <= tx_start ? 3'h3 : (wait_cnt != 3'h0) ? wait_cnt - 3'h1 : 3'h0;
         tx_ok    <= (wait_cnt == 3'h1) && (outcome == 2'h0);
         tx_fail  <= (wait_cnt == 3'h1) && (outcome == 2'h1);
         arb_lost <= (wait_cnt == 3'h1) && (outcome == 2'h2);
      end
   end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
   import can_slot_pkg::*;
   logic        clock = 0, nrst = 0, wr = 0, rd = 0, sof_detect = 0, frame_end = 0;
   logic        rx_done = 0, rx_remote = 0, rx_own = 0, tx_opportunity = 0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, v, w;
   logic [15:0] rx_match = 16'h0, id_seen_match = 16'h0, rx_stamp;
   logic [3:0]  tx_slot, rx_store_slot;
   logic [1:0]  outcome = 2'h0;
   logic        bit_tick, arb_lost, tx_fail, tx_ok, tx_start, tx_remote;
   logic        bus_drive_enable, ack_enable, rx_store, rx_irq, tx_irq;
   int          n_errors = 0, num_checks = 0, n_rx_irq = 0, n_tx_irq = 0, k;
   always #25 clock = ~clock;
   always @(posedge clock) begin
      n_rx_irq += rx_irq;
      n_tx_irq += tx_irq;
   end
   can_message_slot_control DUT (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .bit_tick,
      .sof_detect, .frame_end, .rx_done, .rx_remote, .rx_own, .rx_match, .id_seen_match,
      .tx_opportunity, .arb_lost, .tx_fail, .tx_ok, .tx_start, .tx_slot, .tx_remote,
      .bus_drive_enable, .ack_enable, .rx_store, .rx_store_slot, .rx_stamp, .rx_irq, .tx_irq);
   can_bus_node node (.clock, .nrst, .tx_start, .outcome, .bit_tick, .arb_lost, .tx_fail,
      .tx_ok);
   // =====================================================================
   // bus tasks and expectations
   function automatic logic [31:0] status(logic [3:0] s, logic rxs, logic txs, logic rcv);
      return {24'h0, 1'b0, rcv, txs, rxs, s};
   endfunction
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clock);
      wr <= 0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1;
      @(posedge clock);
      rd <= 0;
      #1 d = rdata;
   endtask
   task automatic rx_frame(input logic [15:0] m, input logic own, input logic rem);
      @(posedge clock);
      rx_done <= 1;
      rx_remote <= rem;
      rx_match <= m;
      rx_own <= own;
      @(posedge clock);
      rx_done <= 0;
      #1;
   endtask
   task automatic tx_try(output logic started);
      @(posedge clock);
      tx_opportunity <= 1;
      @(posedge clock);
      tx_opportunity <= 0;
      #1 started = tx_start;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #200000 n_errors++;
      end_sim();
   end
   // =====================================================================
   // main sequence
   initial begin
      logic st;
      void'($urandom(32'h5bcf90de));
      repeat (2) @(posedge clock);
      nrst <= 1;
      k = $urandom % 4;
      wr_reg(8'h00, k);
      rd_reg(8'h00, v);
      `CHK(v, k)
      rd_reg(8'h0C, v);
      repeat (62) @(posedge clock);
      rd_reg(8'h0C, w);
      `CHK(w - v, 16 >> k)
      @(posedge clock) sof_detect <= 1;
      @(posedge clock) sof_detect <= 0;
      rd_reg(8'h04, v);
      `CHK(v, status(0, 0, 0, 1))
      @(posedge clock) frame_end <= 1;
      @(posedge clock) frame_end <= 0;
      $display("test divider and receiver flag done");
      wr_reg(8'h08, 32'h2C);
      wr_reg(8'h48, 0);
      wr_reg(8'h48, 32'h100);
      wr_reg(8'h54, 32'h100);
      rx_frame(16'h0024 | (16'($urandom) & 16'hFFC0), 0, 0);
      `CHK(rx_store, 1'b1)
      w = 32'(rx_stamp);
      `CHK(rx_store_slot, 4'h2)
      rd_reg(8'h48, v);
      `CHK(v, 32'h105)
      rd_reg(8'h04, v);
      `CHK(v, status(2, 1, 0, 0))
      rd_reg(8'h48, v);
      `CHK(v, 32'h101)
      rd_reg(8'h88, v);
      `CHK(v, w)
      rx_frame(16'h0004, 0, 0);
      repeat (5) @(posedge clock);
      rd_reg(8'h48, v);
      `CHK(v, 32'h109)
      `CHK(n_rx_irq, 2)
      rx_frame(16'h0004, 1, 0);
      `CHK(rx_store, 1'b0)
      $display("test reception done");
      wr_reg(8'h00, 32'h4);
      `CHK({bus_drive_enable, ack_enable}, 2'b00)
      wr_reg(8'h4C, 0);
      wr_reg(8'h4C, 32'h200);
      tx_try(st);
      `CHK(st, 1'b0)
      wr_reg(8'h00, 32'h0);
      outcome <= 2'h2;
      tx_try(st);
      `CHK({st, tx_slot}, 5'h13)
      rd_reg(8'h04, v);
      `CHK(v, status(2, 1, 0, 0) | 32'h80)
      repeat (4) @(posedge clock);
      rd_reg(8'h4C, v);
      `CHK(v, 32'h200)
      outcome <= 2'h1;
      tx_try(st);
      `CHK({st, tx_slot}, 5'h13)
      repeat (6) @(posedge clock);
      outcome <= 2'h0;
      tx_try(st);
      `CHK({st, tx_slot}, 5'h13)
      repeat (6) @(posedge clock);
      rd_reg(8'h04, v);
      `CHK(v, status(3, 0, 1, 0))
      `CHK(n_tx_irq, 1)
      wr_reg(8'h4C, 32'h200);
      rd_reg(8'h4C, v);
      `CHK(v, 32'h202)
      tx_try(st);
      `CHK(st, 1'b0)
      wr_reg(8'h4C, 32'h2);
      wr_reg(8'h4C, 32'h0);
      rd_reg(8'h4C, v);
      `CHK(v, 32'h0)
      $display("test transmission done");
      wr_reg(8'h58, 32'h0);
      wr_reg(8'h58, 32'h280);
      tx_try(st);
      `CHK({st, tx_remote, tx_slot}, 6'h36)
      repeat (6) @(posedge clock);
      rd_reg(8'h58, v);
      `CHK(v, 32'h282)
      rd_reg(8'h04, v);
      `CHK(v, status(6, 0, 1, 0))
      rx_frame(16'h0040, 0, 0);
      `CHK(rx_store_slot, 4'h6)
      wr_reg(8'h5C, 32'h0);
      wr_reg(8'h5C, 32'h280);
      @(posedge clock) id_seen_match <= 16'h0080;
      @(posedge clock) id_seen_match <= 16'h0000;
      rd_reg(8'h5C, v);
      `CHK(v, 32'h280)
      tx_try(st);
      `CHK(st, 1'b0)
      wr_reg(8'h60, 32'h0);
      wr_reg(8'h60, 32'h1C0);
      rx_frame(16'h0100, 0, 1);
      `CHK(rx_store_slot, 4'h8)
      repeat (5) @(posedge clock);
      rd_reg(8'h60, v);
      `CHK(v, 32'h1C1)
      tx_try(st);
      `CHK(st, 1'b0)
      wr_reg(8'h60, 32'h181);
      tx_try(st);
      `CHK({st, tx_remote, tx_slot}, 6'h28)
      repeat (6) @(posedge clock);
      `CHK(n_tx_irq, 1)
      $display("test remote slots done");
      end_sim();
   end
endmodule
`default_nettype wire

/* File: hdl/can_message_slot_control.sv */
// Local design decisions: the register offsets and the plain strobed port.
`include "can_slot_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module can_message_slot_control
   import can_slot_pkg::*;
#(
   parameter int SLOTS        = `SLOT_COUNT,
   parameter int STAMP_W      = `STAMP_WIDTH,
   parameter int STORE_CYCLES = `STORE_CYCLES
) (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 nrst,
   // register port
   input  wire logic [7:0]           addr,
   input  wire logic [31:0]          wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic      [31:0]          rdata,
   // protocol engine events
   input  wire logic                 bit_tick,
   input  wire logic                 sof_detect,
   input  wire logic                 frame_end,
   input  wire logic                 rx_done,
   input  wire logic                 rx_remote,
   input  wire logic                 rx_own,
   input  wire logic [SLOTS-1:0]     rx_match,
   input  wire logic [SLOTS-1:0]     id_seen_match,
   input  wire logic                 tx_opportunity,
   input  wire logic                 arb_lost,
   input  wire logic                 tx_fail,
   input  wire logic                 tx_ok,
   // requests to the protocol engine
   output logic                      tx_start,
   output logic [$clog2(SLOTS)-1:0]  tx_slot,
   output logic                      tx_remote,
   output logic                      bus_drive_enable,
   output logic                      ack_enable,
   // message storage
   output logic                      rx_store,
   output logic [$clog2(SLOTS)-1:0]  rx_store_slot,
   output logic [STAMP_W-1:0]        rx_stamp,
   // success requests
   output logic                      rx_irq,
   output logic                      tx_irq
);
   localparam int SW = $clog2(SLOTS);

   // returns the lowest set index; callers check for any bit set
   function automatic logic [SW-1:0] lowest(input logic [SLOTS-1:0] v);
      lowest = '0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowest = SW'(i);
         end
      end
   endfunction

   // =====================================================================
   // registers
   logic [1:0]          div_sel;
   logic                listen_only;
   logic                loopback;
   logic [SLOTS-1:0]    irq_enable;
   logic [SW-1:0]       last_slot;
   logic                rx_success;
   logic                tx_success;
   logic                receiver;
   tx_state_t           tx_state;
   logic [SW-1:0]       cur_slot;
   logic [SLOTS-1:0]    tr, rr, rs, hold, ra;
   logic [SLOTS-1:0]    fresh, sent, upd, lost, sending;
   logic [STAMP_W-1:0]  stamp_count;
   logic [2:0]          pre_count;
   logic [STAMP_W-1:0]  stamp_mem [SLOTS];
   logic [$clog2(STORE_CYCLES+1)-1:0] store_count;
   logic [SW-1:0]       store_slot;

   // =====================================================================
   // address decode
   wire                 wr_ctrl   = wr && addr == `OFS_CHANNEL_CONTROL;
   wire                 wr_ie     = wr && addr == `OFS_SLOT_IRQ_ENABLE;
   wire                 slot_area = addr[7:6] == `REGION_SLOT_CONTROL;
   wire                 stamp_area = addr[7:6] == `REGION_SLOT_STAMP;
   wire [SW-1:0]        reg_idx   = addr[SW+1:2];
   wire [SLOTS-1:0]     slot_wr   = (wr && slot_area) ? (SLOTS'(1) << reg_idx) : '0;
   wire                 channel_tx = tx_state != TX_IDLE;

   // =====================================================================
   // slot mode decode
   wire [SLOTS-1:0] data_rx_elig = (~tr & rr & ~rs & ~hold)
                                 | (tr & ~rr & rs & ~ra);
   wire [SLOTS-1:0] remote_rx_elig = ~tr & rr & rs & ra;
   wire [SLOTS-1:0] remote_wait  = tr & ~rr & rs & ra & ~sending;
   wire [SLOTS-1:0] pending = ~sent & (
                              (tr & ~rr & ~rs & ~hold)
                            | (tr & ~rr & rs & ra)
                            | (~tr & rr & rs & ~ra & ~hold));
   wire             any_pending = |pending;
   wire [SW-1:0]    next_tx_slot = lowest(pending);

   // =====================================================================
   // reception choice
   wire [SLOTS-1:0] rx_cand   = rx_match & (rx_remote ? remote_rx_elig : data_rx_elig);
   wire             own_block = rx_own && !loopback;
   wire             rx_accept = rx_done && |rx_cand && !own_block;
   wire [SW-1:0]    rx_target = lowest(rx_cand);
   wire [SLOTS-1:0] rx_hit    = rx_accept ? (SLOTS'(1) << rx_target) : '0;
   wire [SLOTS-1:0] id_hit    = id_seen_match & remote_wait;
   wire [SLOTS-1:0] cur_hot   = SLOTS'(1) << cur_slot;
   wire             busy      = tx_state == TX_BUSY;
   wire [SLOTS-1:0] tx_ok_hit = (busy && tx_ok) ? cur_hot : '0;
   wire [SLOTS-1:0] lost_hit  = (busy && arb_lost) ? cur_hot : '0;
   wire             start_now = (tx_state == TX_IDLE && tx_opportunity && any_pending
                                 && !listen_only)
                              || (tx_state == TX_RETRY && tx_opportunity && !listen_only);
   wire [SW-1:0]    start_slot = tx_state == TX_RETRY ? cur_slot : next_tx_slot;
   wire [SLOTS-1:0] start_hit = start_now ? (SLOTS'(1) << start_slot) : '0;
   wire             store_done = store_count == 1;
   wire [SLOTS-1:0] store_hit = store_done ? (SLOTS'(1) << store_slot) : '0;
   wire             store_busy = store_count != 0;

   // =====================================================================
   // bus drive gating
   assign bus_drive_enable = !listen_only;
   assign ack_enable       = !listen_only && !(loopback && channel_tx);

   // =====================================================================
   // channel control and enables
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         div_sel     <= '0;
         listen_only <= 1'b0;
         loopback    <= 1'b0;
         irq_enable  <= '0;
      end else begin
         if (wr_ctrl) begin
            div_sel     <= wdata[`CTL_DIV_HI:`CTL_DIV_LO];
            listen_only <= wdata[`CTL_LISTEN_ONLY];
            loopback    <= wdata[`CTL_LOOPBACK];
         end
         if (wr_ie) begin
            irq_enable <= wdata[SLOTS-1:0];
         end
      end
   end

   // =====================================================================
   // time stamp
   wire [2:0] div_last   = 3'((4'h1 << div_sel) - 4'h1);
   wire       stamp_tick = bit_tick && pre_count >= div_last;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pre_count   <= '0;
         stamp_count <= '0;
      end else if (bit_tick) begin
         pre_count <= stamp_tick ? 3'h0 : 3'(pre_count + 3'h1);
         if (stamp_tick) begin
            stamp_count <= STAMP_W'(stamp_count + 1'b1);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rx_accept) begin
         stamp_mem[rx_target] <= stamp_count;
      end
   end

   // =====================================================================
   // per-slot control flags
   generate
      for (genvar j = 0; j < SLOTS; j++) begin : g_slot
         wire w = slot_wr[j];
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               tr[j] <= 1'b0; rr[j] <= 1'b0; rs[j] <= 1'b0; hold[j] <= 1'b0;
               ra[j] <= 1'b0; fresh[j] <= 1'b0; sent[j] <= 1'b0;
               upd[j] <= 1'b0; lost[j] <= 1'b0; sending[j] <= 1'b0;
            end else begin
               if (w) begin
                  tr[j]   <= wdata[`SC_TRANSMIT_REQUEST];
                  rr[j]   <= wdata[`SC_RECEIVE_REQUEST];
                  rs[j]   <= wdata[`SC_REMOTE_SELECT];
                  hold[j] <= wdata[`SC_RESPONSE_HOLD];
               end
               // remote phase arms only when leaving the idle state
               if (w && !tr[j] && !rr[j]) begin
                  ra[j] <= wdata[`SC_REMOTE_SELECT] &
                           (wdata[`SC_TRANSMIT_REQUEST] | wdata[`SC_RECEIVE_REQUEST]);
               end else if (tx_ok_hit[j] || id_hit[j]) begin
                  ra[j] <= 1'b0;
               end else if (rx_hit[j] && rx_remote) begin
                  ra[j] <= 1'b0;
               end
               // hardware set wins over a software clear
               fresh[j] <= (fresh[j] & ~(w & ~wdata[`SC_FRESH])) | rx_hit[j];
               lost[j]  <= (lost[j] & ~(w & ~wdata[`SC_OVERWRITE]))
                         | (rx_hit[j] & fresh[j]);
               sent[j]  <= (sent[j] & ~(w & ~tr[j] & ~wdata[`SC_SENT]))
                         | tx_ok_hit[j];
               upd[j]   <= rx_hit[j] | (upd[j] & ~store_hit[j]);
               sending[j] <= start_hit[j] |
                             (sending[j] & ~tx_ok_hit[j] & ~lost_hit[j]);
            end
         end
      end
   endgenerate

   // =====================================================================
   // storing and reception report
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         store_count   <= '0;
         store_slot    <= '0;
         rx_store      <= 1'b0;
         rx_store_slot <= '0;
         rx_stamp      <= '0;
         rx_irq        <= 1'b0;
      end else begin
         rx_store <= rx_accept;
         rx_irq   <= rx_accept && irq_enable[rx_target];
         if (rx_accept) begin
            store_count   <= ($bits(store_count))'(STORE_CYCLES);
            store_slot    <= rx_target;
            rx_store_slot <= rx_target;
            rx_stamp      <= stamp_count;
         end else if (store_busy) begin
            store_count <= ($bits(store_count))'(store_count - 1'b1);
         end
      end
   end

   // =====================================================================
   // transmit sequencing
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tx_state  <= TX_IDLE;
         cur_slot  <= '0;
         tx_start  <= 1'b0;
         tx_slot   <= '0;
         tx_remote <= 1'b0;
         tx_irq    <= 1'b0;
      end else begin
         tx_start <= start_now;
         tx_irq   <= busy && tx_ok && irq_enable[cur_slot];
         case (tx_state)
            TX_IDLE, TX_RETRY: begin
               if (start_now) begin
                  tx_state  <= TX_BUSY;
                  cur_slot  <= start_slot;
                  tx_slot   <= start_slot;
                  tx_remote <= tr[start_slot] & rs[start_slot];
               end
            end
            TX_BUSY: begin
               if (arb_lost || tx_ok) begin
                  tx_state <= TX_IDLE;
               end else if (tx_fail) begin
                  tx_state <= TX_RETRY;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // =====================================================================
   // channel status
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         last_slot  <= '0;
         rx_success <= 1'b0;
         tx_success <= 1'b0;
         receiver   <= 1'b0;
      end else begin
         if (sof_detect && tx_state == TX_IDLE && !any_pending) begin
            receiver <= 1'b1;
         end else if (frame_end) begin
            receiver <= 1'b0;
         end
         if (busy && tx_ok) begin
            last_slot  <= cur_slot;
            tx_success <= 1'b1;
            rx_success <= 1'b0;
         end else if (rx_accept && irq_enable[rx_target]) begin
            last_slot  <= rx_target;
            rx_success <= 1'b1;
            tx_success <= 1'b0;
         end
      end
   end

   // =====================================================================
   // read port
   logic [31:0] status_word, slot_word, read_mux;
   assign status_word = 32'({channel_tx, receiver, tx_success, rx_success, 4'(last_slot)});
   assign slot_word   = 32'({tr[reg_idx], rr[reg_idx], rs[reg_idx], hold[reg_idx],
                             ra[reg_idx], sending[reg_idx], lost[reg_idx],
                             upd[reg_idx], sent[reg_idx], fresh[reg_idx]});
   always_comb begin
      if (addr == `OFS_CHANNEL_CONTROL) begin
         read_mux = 32'({loopback, listen_only, div_sel});
      end else if (addr == `OFS_CHANNEL_STATUS) begin
         read_mux = status_word;
      end else if (addr == `OFS_SLOT_IRQ_ENABLE) begin
         read_mux = 32'(irq_enable);
      end else if (addr == `OFS_STAMP_COUNTER) begin
         read_mux = 32'(stamp_count);
      end else if (slot_area) begin
         read_mux = slot_word;
      end else if (stamp_area) begin
         read_mux = 32'(stamp_mem[reg_idx]);
      end else begin
         read_mux = 32'h0000_0000;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata <= '0;
      end else begin
         rdata <= rd ? read_mux : 32'h0000_0000;
      end
   end

   // =====================================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   wire [SLOTS-1:0] sent_locked = sent & tr;
   sequence s_storing;
      store_busy [*4] ##1 !store_busy;
   endsequence

   a_listen_silent: assert property (listen_only |-> !bus_drive_enable && !ack_enable)
      else $error("bus driven in listen-only mode");
   a_stamp_step: assert property (stamp_tick |=> stamp_count == STAMP_W'($past(stamp_count) + 1'b1))
      else $error("stamp counter did not advance on tick");
   a_rx_stamp: assert property (rx_accept |=> rx_store && rx_stamp == $past(stamp_count))
      else $error("stamp not captured on reception");
   a_store_window: assert property (rx_accept && !store_busy |=> s_storing)
      else $error("updating window length wrong");
   a_overwrite_flag: assert property (rx_accept && fresh[rx_target] |=> lost[$past(rx_target)])
      else $error("overwrite not flagged");
   a_tx_lowest: assert property (tx_state == TX_IDLE && start_now |=>
                                 tx_start && tx_slot == $past(next_tx_slot) && channel_tx)
      else $error("transmit did not start lowest pending slot");
   a_arb_clear: assert property (busy && arb_lost |=> !channel_tx && !sending[$past(cur_slot)])
      else $error("arbitration loss left flags set");
   a_retry_same: assert property (busy && tx_fail && !arb_lost && !tx_ok |=>
                                  tx_state == TX_RETRY && cur_slot == $past(cur_slot))
      else $error("failed transmit not retried on same slot");
   a_sent_lock: assert property (|sent_locked |=> (($past(sent_locked) & ~sent) == '0))
      else $error("sent flag cleared while transmit request set");
   a_receiver_flag: assert property (sof_detect && tx_state == TX_IDLE && !any_pending |=> receiver)
      else $error("receiver flag not set on start of frame");
   a_own_ignored: assert property (rx_done && own_block |=> !rx_store)
      else $error("own frame stored outside loopback");
   a_tx_report: assert property (busy && tx_ok |=> tx_success && last_slot == $past(cur_slot))
      else $error("transmit success not reported");
endmodule
`default_nettype wire

/* File: hdl/can_slot_cfg.svh */
`ifndef CAN_SLOT_CFG_SVH
`define CAN_SLOT_CFG_SVH
// =====================================================================
// register map
`define OFS_CHANNEL_CONTROL  8'h00
`define OFS_CHANNEL_STATUS   8'h04
`define OFS_SLOT_IRQ_ENABLE  8'h08
`define OFS_STAMP_COUNTER    8'h0C
`define REGION_SLOT_CONTROL  2'h1
`define REGION_SLOT_STAMP    2'h2
// =====================================================================
// channel control fields
`define CTL_DIV_LO           0
`define CTL_DIV_HI           1
`define CTL_LISTEN_ONLY      2
`define CTL_LOOPBACK         3
// =====================================================================
// channel status fields
`define STA_SLOT_LO          0
`define STA_SLOT_HI          3
`define STA_RX_SUCCESS       4
`define STA_TX_SUCCESS       5
`define STA_RECEIVER         6
`define STA_TRANSMITTER      7
// =====================================================================
// slot control fields
`define SC_FRESH             0
`define SC_SENT              1
`define SC_UPDATING          2
`define SC_OVERWRITE         3
`define SC_SENDING           4
`define SC_REMOTE_ACTIVE     5
`define SC_RESPONSE_HOLD     6
`define SC_REMOTE_SELECT     7
`define SC_RECEIVE_REQUEST   8
`define SC_TRANSMIT_REQUEST  9
// =====================================================================
// sizes, reset values and timing
`define SLOT_COUNT           16
`define STAMP_WIDTH          16
`define STORE_CYCLES         4
`define CONTROL_RESET        4'h0
`endif

/* File: hdl/can_slot_pkg.sv */
package can_slot_pkg;
   typedef enum logic [1:0] {TX_IDLE, TX_BUSY, TX_RETRY} tx_state_t;
endpackage
